// [pkg/pwmsel_defs.svh]
`ifndef PWMSEL_DEFS_SVH
`define PWMSEL_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define PWMSEL_OFS_SEL0      8'h00
`define PWMSEL_OFS_SEL1      8'h04
`define PWMSEL_OFS_TIMEOUT   8'h08
`define PWMSEL_OFS_ADDR      8'h0C
`define PWMSEL_OFS_CTRL      8'h10
`define PWMSEL_OFS_STATUS    8'h14

// ****************************************
// reset values and fields
// ****************************************
`define PWMSEL_SEL0_RST      2'h1
`define PWMSEL_SEL1_RST      2'h0
`define PWMSEL_SEL_MAX       2'h2
`define PWMSEL_TIMEOUT_RST   8'hFF
`define PWMSEL_ADDR_RST      16'hFFFF
`define PWMSEL_CTRL_RESTORE  0
`define PWMSEL_DUTY_W        10
`define PWMSEL_DUTY_FULL     10'h3FF

// ****************************************
// timing
// ****************************************
`define PWMSEL_CLK_HZ        100000000
`define PWMSEL_TICK_MS       100
`define PWMSEL_TICK_CYCLES   ((`PWMSEL_CLK_HZ / 1000) * `PWMSEL_TICK_MS)
`define PWMSEL_PERIOD_NS     64
`define PWMSEL_PERIOD_US     64
`define PWMSEL_PERIOD_CYCLES ((`PWMSEL_PERIOD_US * 1000) / 10)

// ****************************************
// axi responses
// ****************************************
`define PWMSEL_RESP_OKAY     2'h0
`define PWMSEL_RESP_SLVERR   2'h2

`endif

// [pkg/pwmsel_pkg.sv]
package pwmsel_pkg;
   typedef enum logic [1:0] {
      PWMSEL_OFF,
      PWMSEL_RSSI,
      PWMSEL_PASS
   } pwmsel_mode_t;
endpackage

// [rtl/pwmsel_pwm_gen.sv]
`timescale 1ns/10ps
`include "pwmsel_defs.svh"

module pwmsel_pwm_gen #(
   parameter int unsigned PERIOD = `PWMSEL_PERIOD_CYCLES,
   parameter int unsigned DW     = `PWMSEL_DUTY_W
) (
   input  wire logic          i_core_clk,
   input  wire logic          i_rst,
   input  wire logic [DW-1:0] i_duty,
   output logic               o_pwm
);
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic [DW-1:0] duty_lat;
   logic [DW-1:0] next_duty_lat;
   logic          next_pwm;
   logic [31:0]   hi_cycles;

   always_comb begin
      hi_cycles     = (32'(duty_lat) * PERIOD) >> DW;
      next_cnt      = (cnt == 16'(PERIOD - 1)) ? 16'h0000 : cnt + 16'h0001;
      // duty changes only at period start to avoid runt pulses
      next_duty_lat = (cnt == 16'(PERIOD - 1)) ? i_duty : duty_lat;
      next_pwm      = (duty_lat != '0) && (32'(cnt) < hi_cycles);
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         cnt      <= 16'h0000;
         duty_lat <= '0;
         o_pwm    <= 1'b0;
      end else begin
         cnt      <= next_cnt;
         duty_lat <= next_duty_lat;
         o_pwm    <= next_pwm;
      end
   end
endmodule

// [rtl/pwmsel_top.sv]
// How it works
// - first selector takes 0 off, 1 strength, 2 passed analog; resets to 1
// - second selector uses same codes; resets to 0, disabled
// - matching sender address copies channel a to first, channel b to second
// - one 8-bit timeout in 100 ms units for both outputs, reset 0xFF
// - any matching sender packet starts timer; expiry forces both passed duties to zero
// - each valid sample packet reloads the timer to the full setting
// - restore command returns selectors and timeout to defaults, working copy only
// - strength mode output has 64 us period, high time from last packet strength
// - strength output held low after reset until first radio packet
`timescale 1ns/10ps
`include "pwmsel_defs.svh"

module pwmsel_top
   import pwmsel_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `PWMSEL_TICK_CYCLES,
   parameter int unsigned DW          = `PWMSEL_DUTY_W
) (
   input  wire logic          i_core_clk,
   input  wire logic          i_rst,
   // axi4-lite slave
   input  wire logic [7:0]    i_awaddr,
   input  wire logic          i_awvalid,
   output logic               o_awready,
   input  wire logic [31:0]   i_wdata,
   input  wire logic [3:0]    i_wstrb,
   input  wire logic          i_wvalid,
   output logic               o_wready,
   output logic [1:0]         o_bresp,
   output logic               o_bvalid,
   input  wire logic          i_bready,
   input  wire logic [7:0]    i_araddr,
   input  wire logic          i_arvalid,
   output logic               o_arready,
   output logic [31:0]        o_rdata,
   output logic [1:0]         o_rresp,
   output logic               o_rvalid,
   input  wire logic          i_rready,
   // received radio packet events, same clock
   input  wire logic          i_rf_rx,
   input  wire logic [DW-1:0] i_rf_strength,
   input  wire logic          i_io_rx,
   input  wire logic [15:0]   i_io_src_addr,
   input  wire logic [DW-1:0] i_remote_analog_channel_a,
   input  wire logic [DW-1:0] i_remote_analog_channel_b,
   output logic               o_first_pulse_output,
   output logic               o_second_pulse_output
);
   // ****************************************
   // register state
   // ****************************************
   pwmsel_mode_t  sel0, next_sel0;
   pwmsel_mode_t  sel1, next_sel1;
   logic [7:0]    tmo, next_tmo;
   logic [15:0]   src_addr, next_src_addr;
   logic          aw_held, next_aw_held;
   logic [7:0]    aw_addr, next_aw_addr;
   logic          w_held, next_w_held;
   logic [31:0]   w_data, next_w_data;
   logic [3:0]    w_strb, next_w_strb;
   logic          bvalid, next_bvalid;
   logic [1:0]    bresp, next_bresp;
   logic          rvalid, next_rvalid;
   logic [31:0]   rdata, next_rdata;
   logic [1:0]    rresp, next_rresp;

   // ****************************************
   // output state
   // ****************************************
   logic [DW-1:0] rssi, next_rssi;
   logic          rssi_seen, next_rssi_seen;
   logic [DW-1:0] pass0, next_pass0;
   logic [DW-1:0] pass1, next_pass1;
   logic [7:0]    tmr, next_tmr;
   logic [31:0]   tick_cnt, next_tick_cnt;
   logic          tick;
   logic [DW-1:0] duty0, duty1;
   logic          do_write, io_match, expired;

   function automatic logic sel_ok(input logic [1:0] code);
      return code <= `PWMSEL_SEL_MAX;
   endfunction

   function automatic logic [DW-1:0] mode_duty(input pwmsel_mode_t m, input logic [DW-1:0] r,
                                               input logic rs, input logic [DW-1:0] p);
      case (m)
         PWMSEL_RSSI: mode_duty = rs ? r : '0;
         PWMSEL_PASS: mode_duty = p;
         default:     mode_duty = '0;
      endcase
   endfunction

   assign o_awready = !aw_held && !bvalid;
   assign o_wready  = !w_held && !bvalid;
   assign o_arready = !rvalid;
   assign o_bvalid  = bvalid;
   assign o_bresp   = bresp;
   assign o_rvalid  = rvalid;
   assign o_rdata   = rdata;
   assign o_rresp   = rresp;

   // ****************************************
   // bus and configuration
   // ****************************************
   always_comb begin
      next_aw_held  = aw_held;
      next_aw_addr  = aw_addr;
      next_w_held   = w_held;
      next_w_data   = w_data;
      next_w_strb   = w_strb;
      next_bvalid   = bvalid;
      next_bresp    = bresp;
      next_rvalid   = rvalid;
      next_rdata    = rdata;
      next_rresp    = rresp;
      next_sel0     = sel0;
      next_sel1     = sel1;
      next_tmo      = tmo;
      next_src_addr = src_addr;
      if (i_awvalid && o_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
         next_w_held = 1'b1;
         next_w_data = i_wdata;
         next_w_strb = i_wstrb;
      end
      do_write = aw_held && w_held;
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = `PWMSEL_RESP_OKAY;
         case (aw_addr)
            `PWMSEL_OFS_SEL0: begin
               if (w_strb[0] && sel_ok(w_data[1:0]) && w_data[7:2] == 6'h00)
                  next_sel0 = pwmsel_mode_t'(w_data[1:0]);
            end
            `PWMSEL_OFS_SEL1: begin
               if (w_strb[0] && sel_ok(w_data[1:0]) && w_data[7:2] == 6'h00)
                  next_sel1 = pwmsel_mode_t'(w_data[1:0]);
            end
            `PWMSEL_OFS_TIMEOUT: begin
               if (w_strb[0])
                  next_tmo = w_data[7:0];
            end
            `PWMSEL_OFS_ADDR: begin
               if (w_strb[0])
                  next_src_addr[7:0] = w_data[7:0];
               if (w_strb[1])
                  next_src_addr[15:8] = w_data[15:8];
            end
            `PWMSEL_OFS_CTRL: begin
               if (w_strb[0] && w_data[`PWMSEL_CTRL_RESTORE]) begin
                  next_sel0 = pwmsel_mode_t'(`PWMSEL_SEL0_RST);
                  next_sel1 = pwmsel_mode_t'(`PWMSEL_SEL1_RST);
                  next_tmo  = `PWMSEL_TIMEOUT_RST;
               end
            end
            `PWMSEL_OFS_STATUS: ;
            default: next_bresp = `PWMSEL_RESP_SLVERR;
         endcase
      end
      if (bvalid && i_bready)
         next_bvalid = 1'b0;
      if (i_arvalid && o_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = `PWMSEL_RESP_OKAY;
         case (i_araddr)
            `PWMSEL_OFS_SEL0:    next_rdata = {30'h0000_0000, sel0};
            `PWMSEL_OFS_SEL1:    next_rdata = {30'h0000_0000, sel1};
            `PWMSEL_OFS_TIMEOUT: next_rdata = {24'h00_0000, tmo};
            `PWMSEL_OFS_ADDR:    next_rdata = {16'h0000, src_addr};
            `PWMSEL_OFS_CTRL:    next_rdata = 32'h0000_0000;
            `PWMSEL_OFS_STATUS:  next_rdata = {15'h0000, rssi_seen, tmr, 8'h00};
            default: begin
               next_rdata = 32'h0000_0000;
               next_rresp = `PWMSEL_RESP_SLVERR;
            end
         endcase
      end else if (rvalid && i_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         aw_held  <= 1'b0;
         aw_addr  <= 8'h00;
         w_held   <= 1'b0;
         w_data   <= 32'h0000_0000;
         w_strb   <= 4'h0;
         bvalid   <= 1'b0;
         bresp    <= `PWMSEL_RESP_OKAY;
         rvalid   <= 1'b0;
         rdata    <= 32'h0000_0000;
         rresp    <= `PWMSEL_RESP_OKAY;
         sel0     <= pwmsel_mode_t'(`PWMSEL_SEL0_RST);
         sel1     <= pwmsel_mode_t'(`PWMSEL_SEL1_RST);
         tmo      <= `PWMSEL_TIMEOUT_RST;
         src_addr <= `PWMSEL_ADDR_RST;
      end else begin
         aw_held  <= next_aw_held;
         aw_addr  <= next_aw_addr;
         w_held   <= next_w_held;
         w_data   <= next_w_data;
         w_strb   <= next_w_strb;
         bvalid   <= next_bvalid;
         bresp    <= next_bresp;
         rvalid   <= next_rvalid;
         rdata    <= next_rdata;
         rresp    <= next_rresp;
         sel0     <= next_sel0;
         sel1     <= next_sel1;
         tmo      <= next_tmo;
         src_addr <= next_src_addr;
      end
   end

   // ****************************************
   // 100 ms tick, strength capture, passing and timeout
   // ****************************************
   always_comb begin
      tick          = (tick_cnt == TICK_CYCLES - 1);
      next_tick_cnt = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      io_match      = i_io_rx && (i_io_src_addr == src_addr);
      expired       = (tmr == 8'h00);
      next_rssi      = rssi;
      next_rssi_seen = rssi_seen;
      if (i_rf_rx) begin
         next_rssi      = i_rf_strength;
         next_rssi_seen = 1'b1;
      end
      next_pass0 = pass0;
      next_pass1 = pass1;
      next_tmr   = tmr;
      if (io_match) begin
         next_pass0 = i_remote_analog_channel_a;
         next_pass1 = i_remote_analog_channel_b;
         next_tmr   = tmo;
      end else if (tick && !expired) begin
         next_tmr = tmr - 8'h01;
      end else if (expired) begin
         next_pass0 = '0;
         next_pass1 = '0;
      end
      duty0 = mode_duty(sel0, rssi, rssi_seen, pass0);
      duty1 = mode_duty(sel1, rssi, rssi_seen, pass1);
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         tick_cnt  <= 32'h0000_0000;
         rssi      <= '0;
         rssi_seen <= 1'b0;
         pass0     <= '0;
         pass1     <= '0;
         tmr       <= 8'h00;
      end else begin
         tick_cnt  <= next_tick_cnt;
         rssi      <= next_rssi;
         rssi_seen <= next_rssi_seen;
         pass0     <= next_pass0;
         pass1     <= next_pass1;
         tmr       <= next_tmr;
      end
   end

   // ****************************************
   // pulse generators, 64 us period
   // ****************************************
   pwmsel_pwm_gen #(.DW(DW)) u_gen0 (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_duty     (duty0),
      .o_pwm      (o_first_pulse_output)
   );

   pwmsel_pwm_gen #(.DW(DW)) u_gen1 (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_duty     (duty1),
      .o_pwm      (o_second_pulse_output)
   );
endmodule

// [test/pwm_output_select_timeout_tb.sv]
`timescale 1ns/10ps
`include "pwmsel_defs.svh"
module pwm_output_select_timeout_tb;
   logic        i_core_clk = 1'b0, i_rst = 1'b1;
   logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
   logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
   logic [31:0] i_wdata = 32'h0000_0000, o_rdata, d;
   logic [3:0]  i_wstrb = 4'hF;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, i_rf_rx, i_io_rx;
   logic [1:0]  o_bresp, o_rresp, r;
   logic        o_first_pulse_output, o_second_pulse_output;
   logic [9:0]  i_rf_strength, i_remote_analog_channel_a, i_remote_analog_channel_b;
   logic [15:0] i_io_src_addr;
   int          errors = 0, compares = 0, h1, h2;
   always #5 i_core_clk = ~i_core_clk;
   pwmsel_top #(.TICK_CYCLES(500)) uut (
      .i_core_clk                (i_core_clk),
      .i_rst                     (i_rst),
      .i_awaddr                  (i_awaddr),
      .i_awvalid                 (i_awvalid),
      .o_awready                 (o_awready),
      .i_wdata                   (i_wdata),
      .i_wstrb                   (i_wstrb),
      .i_wvalid                  (i_wvalid),
      .o_wready                  (o_wready),
      .o_bresp                   (o_bresp),
      .o_bvalid                  (o_bvalid),
      .i_bready                  (i_bready),
      .i_araddr                  (i_araddr),
      .i_arvalid                 (i_arvalid),
      .o_arready                 (o_arready),
      .o_rdata                   (o_rdata),
      .o_rresp                   (o_rresp),
      .o_rvalid                  (o_rvalid),
      .i_rready                  (i_rready),
      .i_rf_rx                   (i_rf_rx),
      .i_rf_strength             (i_rf_strength),
      .i_io_rx                   (i_io_rx),
      .i_io_src_addr             (i_io_src_addr),
      .i_remote_analog_channel_a (i_remote_analog_channel_a),
      .i_remote_analog_channel_b (i_remote_analog_channel_b),
      .o_first_pulse_output      (o_first_pulse_output),
      .o_second_pulse_output     (o_second_pulse_output)
   );
   pwmsel_remote rm (
      .i_core_clk    (i_core_clk),
      .o_rf_rx       (i_rf_rx),
      .o_rf_strength (i_rf_strength),
      .o_io_rx       (i_io_rx),
      .o_io_src_addr (i_io_src_addr),
      .o_chan_a      (i_remote_analog_channel_a),
      .o_chan_b      (i_remote_analog_channel_b)
   );
   // ****
   // bus and compare tasks
   // ****
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic complete_run;
      if (errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      logic pend, ha, hw, hb;
      pend = 1'b1;
      @(posedge i_core_clk);
      i_awaddr <= a;
      i_awvalid <= 1'b1;
      i_wdata <= v;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      while (pend) begin
         @(posedge i_core_clk);
         ha = i_awvalid & o_awready;
         hw = i_wvalid & o_wready;
         hb = o_bvalid;
         r = o_bresp;
         if (ha) i_awvalid <= 1'b0;
         if (hw) i_wvalid <= 1'b0;
         if (hb) i_bready <= 1'b0;
         if (hb) pend = 1'b0;
      end
   endtask
   task automatic axr(input logic [7:0] a);
      logic pend, ha, hr;
      pend = 1'b1;
      @(posedge i_core_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      while (pend) begin
         @(posedge i_core_clk);
         ha = i_arvalid & o_arready;
         hr = o_rvalid;
         d = o_rdata;
         r = o_rresp;
         if (ha) i_arvalid <= 1'b0;
         if (hr) i_rready <= 1'b0;
         if (hr) pend = 1'b0;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      axw(a, v);
      chk(r, `PWMSEL_RESP_OKAY);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      axr(a);
      chk(r, `PWMSEL_RESP_OKAY);
      chk(d, e);
   endtask
   task automatic meas(input int n);
      h1 = 0;
      h2 = 0;
      repeat (n) begin
         @(negedge i_core_clk);
         // an unknown level counts as high so it cannot hide behind a zero expectation
         h1 += (o_first_pulse_output !== 1'b0);
         h2 += (o_second_pulse_output !== 1'b0);
      end
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_defaults;
      meas(6400);
      chk(h1 + h2, 0);
      rdc(`PWMSEL_OFS_SEL0, 32'h0000_0001);
      rdc(`PWMSEL_OFS_SEL1, 32'h0000_0000);
      rdc(`PWMSEL_OFS_TIMEOUT, 32'h0000_00FF);
   endtask
   task automatic t_strength;
      rm.send_rf(10'h200);
      repeat (7000) @(posedge i_core_clk);
      meas(6400);
      chk(h1, 3200);
      chk(h2, 0);
   endtask
   task automatic t_select;
      for (int k = 0; k < 3; k++) begin
         wr(`PWMSEL_OFS_SEL0, k);
         rdc(`PWMSEL_OFS_SEL0, k);
         wr(`PWMSEL_OFS_SEL1, k);
         rdc(`PWMSEL_OFS_SEL1, k);
      end
      wr(`PWMSEL_OFS_SEL0, 32'h0000_0003);
      rdc(`PWMSEL_OFS_SEL0, 32'h0000_0002);
      wr(`PWMSEL_OFS_SEL1, 32'h0000_0007);
      rdc(`PWMSEL_OFS_SEL1, 32'h0000_0002);
   endtask
   task automatic t_pass;
      wr(`PWMSEL_OFS_ADDR, 32'h0000_1234);
      wr(`PWMSEL_OFS_TIMEOUT, 32'h0000_0032);
      rdc(`PWMSEL_OFS_TIMEOUT, 32'h0000_0032);
      rm.send_io(16'h4321, 10'h100, 10'h300);
      axr(`PWMSEL_OFS_STATUS);
      chk(d[15:8], 8'h00);
      rm.send_io(16'h1234, 10'h100, 10'h300);
      repeat (12800) @(posedge i_core_clk);
      meas(6400);
      chk(h1, 1600);
      chk(h2, 4800);
      rm.send_io(16'h1234, 10'h100, 10'h300);
      repeat (15000) @(posedge i_core_clk);
      axr(`PWMSEL_OFS_STATUS);
      chk(d[15:8] inside {[8'h13:8'h15]}, 1'b1);
      repeat (20000) @(posedge i_core_clk);
      axr(`PWMSEL_OFS_STATUS);
      chk(d[15:8], 8'h00);
      meas(6400);
      chk(h1 + h2, 0);
   endtask
   task automatic t_restore;
      wr(`PWMSEL_OFS_CTRL, 32'h0000_0001);
      rdc(`PWMSEL_OFS_SEL0, 32'h0000_0001);
      rdc(`PWMSEL_OFS_SEL1, 32'h0000_0000);
      rdc(`PWMSEL_OFS_TIMEOUT, 32'h0000_00FF);
      rdc(`PWMSEL_OFS_ADDR, 32'h0000_1234);
      axw(8'h20, 32'h0000_0001);
      chk(r, `PWMSEL_RESP_SLVERR);
      axr(8'h20);
      chk(r, `PWMSEL_RESP_SLVERR);
   endtask
   initial begin
      repeat (12) @(posedge i_core_clk);
      i_rst <= 1'b0;
      t_defaults();
      t_strength();
      t_select();
      t_pass();
      t_restore();
      complete_run();
   end
   initial begin
      repeat (95000) @(posedge i_core_clk);
      errors++;
      complete_run();
   end
endmodule
bind pwmsel_top pwmsel_top_sva #(.TICK_CYCLES(TICK_CYCLES), .DW(DW)) u_sva (
   .i_core_clk            (i_core_clk),
   .i_rst                 (i_rst),
   .i_awaddr              (i_awaddr),
   .i_awvalid             (i_awvalid),
   .o_awready             (o_awready),
   .i_wvalid              (i_wvalid),
   .o_wready              (o_wready),
   .o_bresp               (o_bresp),
   .o_bvalid              (o_bvalid),
   .i_bready              (i_bready),
   .i_arvalid             (i_arvalid),
   .o_arready             (o_arready),
   .o_rdata               (o_rdata),
   .o_rvalid              (o_rvalid),
   .i_rready              (i_rready),
   .i_rf_rx               (i_rf_rx),
   .i_io_rx               (i_io_rx),
   .o_first_pulse_output  (o_first_pulse_output),
   .o_second_pulse_output (o_second_pulse_output)
);

// [test/pwmsel_remote.sv]
`timescale 1ns/10ps
module pwmsel_remote (
   input  wire logic  i_core_clk,
   output logic       o_rf_rx,
   output logic [9:0] o_rf_strength,
   output logic       o_io_rx,
   output logic [15:0] o_io_src_addr,
   output logic [9:0] o_chan_a,
   output logic [9:0] o_chan_b
);
   initial begin
      o_rf_rx = 1'b0;
      o_io_rx = 1'b0;
      o_rf_strength = 10'h155;
      o_io_src_addr = 16'hA5A5;
      o_chan_a = 10'h2AA;
      o_chan_b = 10'h155;
   end
   // payload is inverted after its pulse so stale values are never reused
   task automatic send_rf(input logic [9:0] s);
      @(posedge i_core_clk);
      o_rf_rx <= 1'b1;
      o_rf_strength <= s;
      @(posedge i_core_clk);
      o_rf_rx <= 1'b0;
      o_rf_strength <= ~s;
   endtask
   task automatic send_io(input logic [15:0] a, input logic [9:0] x, input logic [9:0] y);
      @(posedge i_core_clk);
      o_io_rx <= 1'b1;
      o_io_src_addr <= a;
      o_chan_a <= x;
      o_chan_b <= y;
      @(posedge i_core_clk);
      o_io_rx <= 1'b0;
      o_io_src_addr <= ~a;
      o_chan_a <= ~x;
      o_chan_b <= ~y;
   endtask
endmodule

// [test/pwmsel_top_sva.sv]
`timescale 1ns/10ps
`include "pwmsel_defs.svh"
module pwmsel_top_sva #(
   parameter int unsigned TICK_CYCLES = 20,
   parameter int unsigned DW          = 10
) (
   input wire logic        i_core_clk,
   input wire logic        i_rst,
   input wire logic [7:0]  i_awaddr,
   input wire logic        i_awvalid,
   input wire logic        o_awready,
   input wire logic        i_wvalid,
   input wire logic        o_wready,
   input wire logic [1:0]  o_bresp,
   input wire logic        o_bvalid,
   input wire logic        i_bready,
   input wire logic        i_arvalid,
   input wire logic        o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic        o_rvalid,
   input wire logic        i_rready,
   input wire logic        i_rf_rx,
   input wire logic        i_io_rx,
   input wire logic        o_first_pulse_output,
   input wire logic        o_second_pulse_output
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   logic        seen, next_seen, prev;
   logic [7:0]  waddr, next_waddr;
   logic [31:0] gap, next_gap;
   logic        rise;
   // ****
   // helpers: packet seen, write address, cycles since last rise
   // ****
   always_comb begin
      rise = o_first_pulse_output & ~prev;
      next_seen = seen | i_rf_rx | i_io_rx;
      next_waddr = (i_awvalid && o_awready) ? i_awaddr : waddr;
      next_gap = rise ? 32'h0000_0001 : ((gap == 32'h0000_0000) ? gap : gap + 32'h0000_0001);
   end
   always_ff @(posedge i_core_clk) begin
      seen <= i_rst ? 1'b0 : next_seen;
      gap <= i_rst ? 32'h0000_0000 : next_gap;
      prev <= i_rst ? 1'b0 : o_first_pulse_output;
      waddr <= next_waddr;
   end
   property p_idle_out;
      !seen |-> !o_first_pulse_output && !o_second_pulse_output;
   endproperty
   a_idle_out: assert property (p_idle_out) else $error("output active before any packet");
   property p_period;
      rise && gap != 32'h0000_0000 |-> gap % `PWMSEL_PERIOD_CYCLES == 0;
   endproperty
   a_period: assert property (p_period) else $error("pulse period not 6400 cycles");
   property p_wr_lat;
      i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write response late");
   property p_b_hold;
      o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_b_block;
      o_bvalid |-> !o_awready && !o_wready;
   endproperty
   a_b_block: assert property (p_b_block) else $error("write accepted during response");
   property p_b_code;
      $rose(o_bvalid) |-> o_bresp == ((waddr <= `PWMSEL_OFS_STATUS && waddr[1:0] == 2'h0) ?
                                      `PWMSEL_RESP_OKAY : `PWMSEL_RESP_SLVERR);
   endproperty
   a_b_code: assert property (p_b_code) else $error("wrong write response code");
   property p_rd_lat;
      i_arvalid && o_arready |=> o_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read data late");
   property p_r_hold;
      o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   c_rise: cover property (rise);
   c_slverr: cover property (o_bvalid && o_bresp == 2'h2);
   c_io: cover property (i_io_rx);
   c_second: cover property (o_second_pulse_output);
endmodule
